// ### lrst_params.svh
`ifndef LRST_PARAMS_SVH
`define LRST_PARAMS_SVH
// How it works
// R1: a three-bit sticky record shows which reset sources fired since last read.
// R2: any host access to the reset record clears all its bits.
// R3: bit 2 shows a global reset requested over the host link.
// R4: bit 1 shows a power-on reset; bit value follows the reset generator.
// R5: bit 0 shows the external reset pin; undefined after power-on reset.
// R6: memory self-test starts only when key b157 is written.
// R7: start accepted only while both code RAMs are unlocked by the host.
// R8: self-test read returns outcome: 00 never, 01 running, 10 pass, 11 fail.
// R9: complete self-test takes about 2.2 ms at 24 MHz.
// R10: ten write-then-read passes, one per pattern, cover the whole RAM.
// R11: writing 1 to lock bit 0 enters protect mode.
// R12: in protect mode lockable registers refuse host writes, stay readable.
// R13: protect mode clears only by writing key 1337 to the release register.
// R14: the correct release key clears every lock bit, tail bits included.
// R15: data RAM tails are protected only by lock bits 1 and 2.
// R16: clear-on-read applies to host reads only, never backdoor reads.
// R17: behaviour bit 0 makes the driver status register clear on read.
// R18: behaviour bits 1 to 4 make diagnosis pairs clear on read.
// R19: behaviour bits 5 to 8 make core status registers clear on read.
// R20: a core write colliding with a host read shows on the next read.
// R21: wrong keys to self-test or release register change nothing.
// R22: reserved bits read zero and ignore writes.

`define LRST_ADDR_W      9
`define LRST_DATA_W      16
`define LRST_OFS_LOCK    9'h1cd
`define LRST_OFS_BEHAV   9'h1ce
`define LRST_OFS_RELEASE 9'h1cf
`define LRST_OFS_CAUSE   9'h1d6
`define LRST_OFS_TEST    9'h1dc
`define LRST_OFS_DIAG    {9'h168, 9'h166, 9'h164, 9'h162}
`define LRST_KEY_TEST    16'hb157
`define LRST_KEY_RELEASE 16'h1337
`define LRST_LOCK_W      3
`define LRST_BIT_GLOBAL  0
`define LRST_BIT_TAIL1   1
`define LRST_BIT_TAIL2   2
`define LRST_RST_LOCK    3'h0
`define LRST_BEHAV_W     9
`define LRST_BIT_DRV     0
`define LRST_DIAG_LSB    1
`define LRST_STAT_LSB    5
`define LRST_RST_BEHAV   9'h000
`define LRST_CAUSE_W     3
`define LRST_RST_CAUSE   3'h0
`define LRST_OUT_W       2
`define LRST_OUT_NONE    2'h0
`define LRST_OUT_RUN     2'h1
`define LRST_OUT_PASS    2'h2
`define LRST_OUT_FAIL    2'h3
`define LRST_TEST_NS     2200000
`define LRST_REF_MHZ     24
`define LRST_TEST_CYC    (`LRST_TEST_NS * `LRST_REF_MHZ / 1000)
`define LRST_NPAT        10
`define LRST_MEM_DEPTH   (`LRST_TEST_CYC / (2 * `LRST_NPAT))
`define LRST_PATTERNS    {8'h00, 8'hff, 8'hff, 8'h00, 8'hf0, 8'h0f, 8'haa, 8'h55, 8'h11, 8'h00}
`endif

// ### lrst_pkg.sv
`default_nettype none
package lrst_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10,
    ST_LAST  = 2'b11
  } lrst_state_t;
endpackage
`default_nettype wire

// ### lrst_selftest_engine.sv
`timescale 1ns/100ps
`default_nettype none
`include "lrst_params.svh"
module lrst_selftest_engine #(
  parameter int MEM_DEPTH = `LRST_MEM_DEPTH,
  parameter int MEM_W     = 8,
  parameter int AW        = $clog2(MEM_DEPTH)
) (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             start_i,
  output logic                  busy_o,
  output logic                  done_o,
  output logic                  fail_o,
  output logic [AW-1:0]         mem_addr_o,
  output logic                  mem_we_o,
  output logic                  mem_re_o,
  output logic [MEM_W-1:0]      mem_wdata_o,
  input  wire logic [MEM_W-1:0] mem_rdata_i
);
  localparam logic [AW-1:0]           LAST_A  = AW'(MEM_DEPTH - 1);
  localparam logic [8*`LRST_NPAT-1:0] PATS    = `LRST_PATTERNS;

  // refuse a geometry the address counter or pattern replication cannot serve
  if (MEM_DEPTH < 2 || MEM_W % 8 != 0 || AW < $clog2(MEM_DEPTH)) begin : g_bad_geometry
    $error("bad self-test geometry");
  end

  function automatic logic [MEM_W-1:0] pattern(input logic [3:0] idx);
    pattern = {(MEM_W/8){PATS[8*idx +: 8]}};
  endfunction

  lrst_pkg::lrst_state_t state_q, state_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [3:0]    pat_q, pat_d;
  logic          chk_q, chk_d, err_q, err_d, done_q, done_d, fail_q, fail_d;
  logic          err_now;

  // ----------------------------------------------------------------
  // march sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    addr_d   = addr_q;
    pat_d    = pat_q;
    chk_d    = 1'b0;
    done_d   = 1'b0;
    fail_d   = fail_q;
    mem_we_o = 1'b0;
    mem_re_o = 1'b0;
    err_now  = err_q | (chk_q & (mem_rdata_i != pattern(pat_q)));
    err_d    = err_now;
    case (state_q)
      lrst_pkg::ST_IDLE: begin
        if (start_i) begin
          state_d = lrst_pkg::ST_WRITE;
          addr_d  = '0;
          pat_d   = 4'h0;
          err_d   = 1'b0;
        end
      end
      lrst_pkg::ST_WRITE: begin
        mem_we_o = 1'b1; // [R10]
        addr_d   = (addr_q == LAST_A) ? '0 : addr_q + 1'b1;
        if (addr_q == LAST_A) begin
          state_d = lrst_pkg::ST_READ;
        end
      end
      lrst_pkg::ST_READ: begin
        mem_re_o = 1'b1;
        chk_d    = 1'b1;
        addr_d   = (addr_q == LAST_A) ? addr_q : addr_q + 1'b1;
        if (addr_q == LAST_A) begin
          state_d = lrst_pkg::ST_LAST;
        end
      end
      lrst_pkg::ST_LAST: begin
        addr_d = '0;
        if (pat_q == 4'(`LRST_NPAT - 1)) begin
          state_d = lrst_pkg::ST_IDLE; // [R10]
          done_d  = 1'b1;
          fail_d  = err_now;
        end else begin
          state_d = lrst_pkg::ST_WRITE;
          pat_d   = pat_q + 4'h1;
        end
      end
      default: begin
        state_d = lrst_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= lrst_pkg::ST_IDLE;
      addr_q  <= '0;
      pat_q   <= 4'h0;
      chk_q   <= 1'b0;
      err_q   <= 1'b0;
      done_q  <= 1'b0;
      fail_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q  <= addr_d;
      pat_q   <= pat_d;
      chk_q   <= chk_d;
      err_q   <= err_d;
      done_q  <= done_d;
      fail_q  <= fail_d;
    end
  end

  assign busy_o      = (state_q != lrst_pkg::ST_IDLE);
  assign done_o      = done_q;
  assign fail_o      = fail_q;
  assign mem_addr_o  = addr_q;
  assign mem_wdata_o = pattern(pat_q);

  // ----------------------------------------------------------------
  // run length check
  // ----------------------------------------------------------------
  int unsigned run_cnt_q, run_cnt_d;
  always_comb begin
    run_cnt_d = busy_o ? run_cnt_q + 1 : (start_i ? 0 : run_cnt_q);
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_cnt_q <= 0;
    end else begin
      run_cnt_q <= run_cnt_d;
    end
  end

  a_run_length: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R9]
    done_q |-> run_cnt_q == `LRST_NPAT * (2 * MEM_DEPTH + 1))
    else $error("self-test run length wrong");
endmodule
`default_nettype wire

// ### lrst_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "lrst_params.svh"
module lrst_ctrl #(
  parameter int                MEM_DEPTH   = `LRST_MEM_DEPTH,
  parameter int                MEM_W       = 8,
  parameter int                AW          = $clog2(MEM_DEPTH),
  parameter logic [8:0]        DRV_ADDR    = 9'h1c8,
  parameter logic [3:0][8:0]   STAT_ADDR   = {9'h12f, 9'h12e, 9'h10f, 9'h10e}
) (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             spi_wr_i,
  input  wire logic             spi_rd_i,
  input  wire logic [8:0]       spi_addr_i,
  input  wire logic [15:0]      spi_wdata_i,
  input  wire logic             core_rd_i,
  input  wire logic [8:0]       core_addr_i,
  output logic [15:0]           rdata_o,
  output logic                  rdata_valid_o,
  input  wire logic             pin_reset_seen_i,
  input  wire logic             power_on_reset_seen_i,
  input  wire logic             spi_reset_seen_i,
  input  wire logic             code_ram1_unlocked_i,
  input  wire logic             code_ram2_unlocked_i,
  output logic                  global_protect_o,
  output logic                  data_ram1_tail_protect_o,
  output logic                  data_ram2_tail_protect_o,
  output logic                  drive_status_clear_o,
  output logic [3:0]            diag_clear_o,
  output logic [3:0]            status_clear_o,
  output logic                  selftest_busy_o,
  output logic [AW-1:0]         mem_addr_o,
  output logic                  mem_we_o,
  output logic                  mem_re_o,
  output logic [MEM_W-1:0]      mem_wdata_o,
  input  wire logic [MEM_W-1:0] mem_rdata_i
);
  localparam logic [4*`LRST_ADDR_W-1:0] DIAG_BASE = `LRST_OFS_DIAG;

  function automatic logic pair_hit(input logic [8:0] a, input logic [8:0] base);
    pair_hit = (a[8:1] == base[8:1]);
  endfunction

  function automatic logic [15:0] widen(input logic [8:0] v);
    widen = {7'h00, v};
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr_lock, wr_behav, wr_release, wr_test, hit_cause;
  logic key_release, key_test, start_ok;

  assign wr_lock     = spi_wr_i && (spi_addr_i == `LRST_OFS_LOCK);
  assign wr_behav    = spi_wr_i && (spi_addr_i == `LRST_OFS_BEHAV);
  assign wr_release  = spi_wr_i && (spi_addr_i == `LRST_OFS_RELEASE);
  assign wr_test     = spi_wr_i && (spi_addr_i == `LRST_OFS_TEST);
  assign hit_cause   = (spi_wr_i || spi_rd_i) && (spi_addr_i == `LRST_OFS_CAUSE);
  assign key_release = wr_release && (spi_wdata_i == `LRST_KEY_RELEASE); // [R13] [R21]
  assign key_test    = wr_test && (spi_wdata_i == `LRST_KEY_TEST); // [R6] [R21]

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  logic [`LRST_LOCK_W-1:0]  lock_q, lock_d;
  logic [`LRST_BEHAV_W-1:0] behav_q, behav_d;
  logic [`LRST_CAUSE_W-1:0] cause_q, cause_d;
  logic [`LRST_OUT_W-1:0]   outcome_q, outcome_d;
  logic                     armed_q, armed_d;
  logic                     eng_busy, eng_done, eng_fail;

  assign start_ok = key_test && code_ram1_unlocked_i && code_ram2_unlocked_i // [R7]
                    && (outcome_q != `LRST_OUT_RUN);

  always_comb begin
    lock_d    = lock_q;
    behav_d   = behav_q;
    cause_d   = cause_q;
    outcome_d = outcome_q;
    armed_d   = 1'b1;
    if (key_release) begin
      lock_d = `LRST_RST_LOCK; // [R14]
    end else if (wr_lock) begin
      // bits only set here; clearing needs the release key
      lock_d = lock_q | spi_wdata_i[`LRST_LOCK_W-1:0]; // [R11] [R13] [R22]
    end
    if (wr_behav) begin
      behav_d = spi_wdata_i[`LRST_BEHAV_W-1:0]; // [R22]
    end
    if (!armed_q) begin
      // capture the causes once after reset release; wins over a clear
      cause_d = {spi_reset_seen_i, power_on_reset_seen_i, pin_reset_seen_i}; // [R1] [R3] [R4] [R5]
    end else if (hit_cause) begin
      cause_d = `LRST_RST_CAUSE; // [R2]
    end
    if (start_ok) begin
      outcome_d = `LRST_OUT_RUN; // [R6]
    end else if (eng_done) begin
      outcome_d = eng_fail ? `LRST_OUT_FAIL : `LRST_OUT_PASS; // [R8]
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_q    <= `LRST_RST_LOCK;
      behav_q   <= `LRST_RST_BEHAV;
      cause_q   <= `LRST_RST_CAUSE;
      outcome_q <= `LRST_OUT_NONE;
      armed_q   <= 1'b0;
    end else begin
      lock_q    <= lock_d;
      behav_q   <= behav_d;
      cause_q   <= cause_d;
      outcome_q <= outcome_d;
      armed_q   <= armed_d;
    end
  end

  // lockable registers elsewhere gate host writes on this level
  assign global_protect_o         = lock_q[`LRST_BIT_GLOBAL]; // [R12]
  assign data_ram1_tail_protect_o = lock_q[`LRST_BIT_TAIL1]; // [R15]
  assign data_ram2_tail_protect_o = lock_q[`LRST_BIT_TAIL2]; // [R15]
  assign selftest_busy_o          = eng_busy;

  // ----------------------------------------------------------------
  // read path and clear-on-read strobes
  // ----------------------------------------------------------------
  logic [15:0] rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  logic        drv_clr_q, drv_clr_d;
  logic [3:0]  diag_clr_q, diag_clr_d, stat_clr_q, stat_clr_d;
  logic [8:0]  rd_addr;

  always_comb begin
    rd_addr    = spi_rd_i ? spi_addr_i : core_addr_i;
    rvalid_d   = spi_rd_i || core_rd_i;
    rdata_d    = rdata_q;
    drv_clr_d  = 1'b0;
    diag_clr_d = 4'h0;
    stat_clr_d = 4'h0;
    if (rvalid_d) begin
      case (rd_addr)
        `LRST_OFS_LOCK:  rdata_d = widen({6'h00, lock_q});
        `LRST_OFS_BEHAV: rdata_d = widen(behav_q);
        `LRST_OFS_CAUSE: rdata_d = widen({6'h00, cause_q}); // [R1]
        `LRST_OFS_TEST:  rdata_d = widen({7'h00, outcome_q}); // [R8]
        default:         rdata_d = 16'h0000; // [R22]
      endcase
    end
    // only host reads strobe; backdoor reads leave targets intact
    if (spi_rd_i) begin
      drv_clr_d = behav_q[`LRST_BIT_DRV] && (spi_addr_i == DRV_ADDR); // [R16] [R17]
      for (int i = 0; i < 4; i++) begin
        diag_clr_d[i] = behav_q[`LRST_DIAG_LSB + i] // [R18]
                        && pair_hit(spi_addr_i, DIAG_BASE[9*i +: 9]);
        stat_clr_d[i] = behav_q[`LRST_STAT_LSB + i] // [R19]
                        && (spi_addr_i == STAT_ADDR[i]);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q    <= 16'h0000;
      rvalid_q   <= 1'b0;
      drv_clr_q  <= 1'b0;
      diag_clr_q <= 4'h0;
      stat_clr_q <= 4'h0;
    end else begin
      rdata_q    <= rdata_d;
      rvalid_q   <= rvalid_d;
      drv_clr_q  <= drv_clr_d;
      diag_clr_q <= diag_clr_d;
      stat_clr_q <= stat_clr_d;
    end
  end

  // target registers give a same-cycle core write priority over this strobe
  assign rdata_o              = rdata_q;
  assign rdata_valid_o        = rvalid_q;
  assign drive_status_clear_o = drv_clr_q; // [R20]
  assign diag_clear_o         = diag_clr_q; // [R20]
  assign status_clear_o       = stat_clr_q; // [R20]

  // ----------------------------------------------------------------
  // self-test engine
  // ----------------------------------------------------------------
  lrst_selftest_engine #(
    .MEM_DEPTH (MEM_DEPTH),
    .MEM_W     (MEM_W),
    .AW        (AW)
  ) u_engine (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .start_i     (start_ok),
    .busy_o      (eng_busy),
    .done_o      (eng_done),
    .fail_o      (eng_fail),
    .mem_addr_o  (mem_addr_o),
    .mem_we_o    (mem_we_o),
    .mem_re_o    (mem_re_o),
    .mem_wdata_o (mem_wdata_o),
    .mem_rdata_i (mem_rdata_i)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_start_req;
    key_test && code_ram1_unlocked_i && code_ram2_unlocked_i
    && (outcome_q != `LRST_OUT_RUN);
  endsequence

  sequence s_running;
    (outcome_q == `LRST_OUT_RUN) && eng_busy;
  endsequence

  a_cause_capture: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R3] [R4] [R5]
    !armed_q |=> cause_q == $past({spi_reset_seen_i, power_on_reset_seen_i, pin_reset_seen_i}))
    else $error("reset causes not captured");

  a_cause_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R2]
    armed_q && hit_cause |=> cause_q == `LRST_RST_CAUSE)
    else $error("reset record not cleared by access");

  a_cause_sticky: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R1]
    armed_q && !hit_cause |=> $stable(cause_q))
    else $error("reset record changed without access");

  a_test_start: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R6] [R7]
    s_start_req |=> s_running [*2])
    else $error("self-test did not start");

  a_test_refuse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R7] [R21]
    wr_test && !start_ok && !eng_done |=> $stable(outcome_q))
    else $error("refused self-test request changed outcome");

  a_test_outcome: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R8]
    eng_done |=> outcome_q == ($past(eng_fail) ? `LRST_OUT_FAIL : `LRST_OUT_PASS))
    else $error("self-test outcome wrong");

  a_lock_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R11] [R13]
    global_protect_o && !key_release |=> global_protect_o)
    else $error("protect mode left without release key");

  a_release_all: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R14]
    key_release |=> !global_protect_o && !data_ram1_tail_protect_o
                    && !data_ram2_tail_protect_o)
    else $error("release key left lock bits set");

  a_tail_apart: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R15]
    wr_lock && !spi_wdata_i[`LRST_BIT_TAIL1] && !data_ram1_tail_protect_o
    |=> !data_ram1_tail_protect_o)
    else $error("tail protect set by global write");

  a_backdoor_keep: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R16]
    !spi_rd_i |=> !drive_status_clear_o && diag_clear_o == 4'h0 && status_clear_o == 4'h0)
    else $error("clear strobe without host read");

  a_drv_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R17]
    spi_rd_i && (spi_addr_i == DRV_ADDR) && behav_q[`LRST_BIT_DRV] |=> drive_status_clear_o)
    else $error("driver status clear missing");

  a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R22]
    rdata_valid_o |-> rdata_o[15:9] == 7'h00)
    else $error("reserved read bits not zero");
endmodule
`default_nettype wire

// ### lrst_ctrl_note_end.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### lrst_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// test ram behind the self-test port
// ----------------------------------------------------------------
module lrst_ram_model #(
  parameter int DEPTH = 4,
  parameter int W     = 8,
  parameter int AW    = 2
) (
  input  wire logic          sys_clk_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic          we_i,
  input  wire logic          re_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic          fault_i,
  output logic [W-1:0]       rdata_o
);
  logic [W-1:0] mem [DEPTH];

  // answer one cycle after the read strobe; bit 0 inverted when fault_i is set
  // between reads the data lines toggle so stale data never looks valid
  always @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_o <= mem[addr_i] ^ {{(W-1){1'b0}}, fault_i};
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule
`default_nettype wire

// ### lrst_tb.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int              DEPTH = 4;
  localparam logic [8:0]      DRV   = 9'h1c8;
  localparam logic [3:0][8:0] STAT  = {9'h12f, 9'h12e, 9'h10f, 9'h10e};
  localparam logic [7:0]      PAT [10] = '{8'h00, 8'h11, 8'h55, 8'haa, 8'h0f,
                                           8'hf0, 8'h00, 8'hff, 8'hff, 8'h00};

  logic        sys_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        spi_wr_i = 1'b0;
  logic        spi_rd_i = 1'b0;
  logic [8:0]  spi_addr_i = 9'h000;
  logic [15:0] spi_wdata_i = 16'h0000;
  logic        core_rd_i = 1'b0;
  logic [8:0]  core_addr_i = 9'h000;
  logic        pin_i = 1'b0;
  logic        por_i = 1'b0;
  logic        spirst_i = 1'b0;
  logic        cram1_i = 1'b0;
  logic        cram2_i = 1'b0;
  logic        fault = 1'b0;
  logic [15:0] rdata_o;
  logic        rdata_valid_o;
  logic        global_protect_o;
  logic        tail1_o;
  logic        tail2_o;
  logic        drv_clr_o;
  logic [3:0]  diag_clr_o;
  logic [3:0]  stat_clr_o;
  logic        selftest_busy_o;
  logic [1:0]  mem_addr;
  logic        mem_we;
  logic        mem_re;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  int          n_fail = 0;
  int          total_checks = 0;
  int          wr_cnt = 0;

  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  lrst_ctrl #(.MEM_DEPTH(DEPTH), .MEM_W(8), .DRV_ADDR(DRV), .STAT_ADDR(STAT)) lrst_ctrl_inst (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .spi_wr_i(spi_wr_i), .spi_rd_i(spi_rd_i),
    .spi_addr_i(spi_addr_i), .spi_wdata_i(spi_wdata_i), .core_rd_i(core_rd_i),
    .core_addr_i(core_addr_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
    .pin_reset_seen_i(pin_i), .power_on_reset_seen_i(por_i), .spi_reset_seen_i(spirst_i),
    .code_ram1_unlocked_i(cram1_i), .code_ram2_unlocked_i(cram2_i),
    .global_protect_o(global_protect_o), .data_ram1_tail_protect_o(tail1_o),
    .data_ram2_tail_protect_o(tail2_o), .drive_status_clear_o(drv_clr_o),
    .diag_clear_o(diag_clr_o), .status_clear_o(stat_clr_o),
    .selftest_busy_o(selftest_busy_o), .mem_addr_o(mem_addr), .mem_we_o(mem_we),
    .mem_re_o(mem_re), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata));

  lrst_ram_model #(.DEPTH(DEPTH), .W(8), .AW(2)) lrst_ram_model_inst (
    .sys_clk_i(sys_clk_i), .addr_i(mem_addr), .we_i(mem_we), .re_i(mem_re),
    .wdata_i(mem_wdata), .fault_i(fault), .rdata_o(mem_rdata));

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // every self-test write carries its pass pattern, addresses in order
  always @(negedge sys_clk_i) begin
    if (mem_we === 1'b1) begin
      chk("pattern", {6'h00, 2'(wr_cnt % DEPTH), PAT[(wr_cnt / DEPTH) % 10]},
          {6'h00, mem_addr, mem_wdata});
      wr_cnt++;
    end
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic do_reset(input logic pin, input logic por, input logic spir);
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    pin_i <= pin;
    por_i <= por;
    spirst_i <= spir;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    pin_i <= 1'b0;
    por_i <= 1'b0;
    spirst_i <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    spi_wr_i <= 1'b1;
    spi_addr_i <= a;
    spi_wdata_i <= d;
    @(posedge sys_clk_i);
    spi_wr_i <= 1'b0;
    #1;
  endtask

  // host or backdoor read; checks data, valid and the clear strobes
  task automatic rd(input logic core, input logic [8:0] a, input logic [15:0] exp,
                    input logic drv, input logic [3:0] dg, input logic [3:0] st);
    @(posedge sys_clk_i);
    spi_rd_i <= ~core;
    core_rd_i <= core;
    spi_addr_i <= a;
    core_addr_i <= a;
    @(posedge sys_clk_i);
    spi_rd_i <= 1'b0;
    core_rd_i <= 1'b0;
    #1;
    chk("valid", 16'h0001, {15'h0000, rdata_valid_o});
    chk("rdata", exp, rdata_o);
    chk("strobes", {7'h00, drv, dg, st}, {7'h00, drv_clr_o, diag_clr_o, stat_clr_o});
  endtask

  task automatic run_test(input logic flt, input logic [1:0] outcome);
    int n;
    @(posedge sys_clk_i);
    fault <= flt;
    wr(9'h1dc, 16'hb157);
    rd(1'b0, 9'h1dc, 16'h0001, 1'b0, 4'h0, 4'h0);
    n = 2;
    while (selftest_busy_o === 1'b1 && n < 300) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk("busy cycles", 16'(10 * (2 * DEPTH + 1)), 16'(n));
    rd(1'b0, 9'h1dc, {14'h0000, outcome}, 1'b0, 4'h0, 4'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset(1'b1, 1'b1, 1'b0);
    rd(1'b0, 9'h1cd, 16'h0000, 1'b0, 4'h0, 4'h0);
    rd(1'b0, 9'h1ce, 16'h0000, 1'b0, 4'h0, 4'h0);
    rd(1'b0, 9'h1dc, 16'h0000, 1'b0, 4'h0, 4'h0);
    rd(1'b1, 9'h1d6, 16'h0003, 1'b0, 4'h0, 4'h0);
    rd(1'b0, 9'h1d6, 16'h0003, 1'b0, 4'h0, 4'h0);
    rd(1'b0, 9'h1d6, 16'h0000, 1'b0, 4'h0, 4'h0);
    do_reset(1'b0, 1'b0, 1'b1);
    rd(1'b1, 9'h1d6, 16'h0004, 1'b0, 4'h0, 4'h0);
    wr(9'h1d6, 16'hffff);
    rd(1'b0, 9'h1d6, 16'h0000, 1'b0, 4'h0, 4'h0);
    // self-test: refused while a code ram is locked or the key is wrong
    @(posedge sys_clk_i);
    cram1_i <= 1'b1;
    wr(9'h1dc, 16'hb157);
    chk("busy", 16'h0000, {15'h0000, selftest_busy_o});
    @(posedge sys_clk_i);
    cram2_i <= 1'b1;
    wr(9'h1dc, 16'hb156);
    rd(1'b0, 9'h1dc, 16'h0000, 1'b0, 4'h0, 4'h0);
    run_test(1'b0, 2'h2);
    run_test(1'b1, 2'h3);
    // protect mode and tail protection
    wr(9'h1cd, 16'h0001);
    chk("protect", 16'h0001, {13'h0000, tail2_o, tail1_o, global_protect_o});
    wr(9'h1cd, 16'h0000);
    wr(9'h1cf, 16'h1336);
    chk("protect", 16'h0001, {13'h0000, tail2_o, tail1_o, global_protect_o});
    wr(9'h1cd, 16'hfff6);
    rd(1'b0, 9'h1cd, 16'h0007, 1'b0, 4'h0, 4'h0);
    rd(1'b0, 9'h1cf, 16'h0000, 1'b0, 4'h0, 4'h0);
    wr(9'h1cf, 16'h1337);
    rd(1'b0, 9'h1cd, 16'h0000, 1'b0, 4'h0, 4'h0);
    chk("protect", 16'h0000, {13'h0000, tail2_o, tail1_o, global_protect_o});
    wr(9'h1cd, 16'h0004);
    chk("protect", 16'h0004, {13'h0000, tail2_o, tail1_o, global_protect_o});
    wr(9'h1cf, 16'h1337);
    // clear-on-read selection: no strobes while the behaviour bits are clear
    rd(1'b0, DRV, 16'h0000, 1'b0, 4'h0, 4'h0);
    wr(9'h1ce, 16'hffff);
    rd(1'b0, 9'h1ce, 16'h01ff, 1'b0, 4'h0, 4'h0);
    rd(1'b0, DRV, 16'h0000, 1'b1, 4'h0, 4'h0);
    rd(1'b1, DRV, 16'h0000, 1'b0, 4'h0, 4'h0);
    for (int i = 0; i < 4; i++) begin
      rd(1'b0, 9'(9'h162 + 2 * i), 16'h0000, 1'b0, 4'(1 << i), 4'h0);
      rd(1'b0, 9'(9'h163 + 2 * i), 16'h0000, 1'b0, 4'(1 << i), 4'h0);
      rd(1'b1, 9'(9'h162 + 2 * i), 16'h0000, 1'b0, 4'h0, 4'h0);
      rd(1'b0, STAT[i], 16'h0000, 1'b0, 4'h0, 4'(1 << i));
      rd(1'b1, STAT[i], 16'h0000, 1'b0, 4'h0, 4'h0);
    end
    wr(9'h1ce, 16'h0000);
    rd(1'b0, 9'h162, 16'h0000, 1'b0, 4'h0, 4'h0);
    chk("pattern writes", 16'(2 * 10 * DEPTH), 16'(wr_cnt));
    stop_test();
  end
endmodule
`default_nettype wire
